//--- hdl/lzpd_ctrl.sv
/*
  Calibration scheduling and power-down state keeping inside the memory die.
  Assumes CKE, CS_N and CA are synchronous to REF_CLK, the controller keeps
  its own timing duties, and bank activity is reported by the core.
  The resistor strap is a board pin with no relation to REF_CLK.
*/
`include "lzpd_params.svh"
module lzpd_ctrl
  import lzpd_pkg::*;
#(
  parameter int ZQINIT_CYC = `LZPD_ZQINIT_CYC,
  parameter int ZQCL_CYC = `LZPD_ZQCL_CYC,
  parameter int ZQCS_CYC = `LZPD_ZQCS_CYC,
  parameter int XP_CYC = `LZPD_XP_CYC
)
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CKE,
  input wire logic CS_N,
  input wire logic [9:0] CA_RISE,
  input wire logic [9:0] CA_FALL,
  input wire logic BANKS_OPEN,
  input wire logic ZQ_TIED_HIGH,
  input wire logic INIT_DONE,
  output logic ZQ_CURRENT_EN,
  output logic ZQ_BUSY,
  output logic [1:0] ZQ_CODE_SEL,
  output logic INPUT_BUF_EN,
  output logic OUTPUT_BUF_EN,
  output logic CORE_POWER_EN,
  output logic REFRESH_EN,
  output lzpd_status_type STATUS
);
  // Counter loads, cut to the counter width on purpose
  localparam logic [`LZPD_CNT_W-1:0] ZQINIT_LD = `LZPD_CNT_W'(ZQINIT_CYC);
  localparam logic [`LZPD_CNT_W-1:0] ZQCL_LD = `LZPD_CNT_W'(ZQCL_CYC);
  localparam logic [`LZPD_CNT_W-1:0] ZQCS_LD = `LZPD_CNT_W'(ZQCS_CYC);
  localparam logic [`LZPD_CNT_W-1:0] XP_LD = `LZPD_CNT_W'(XP_CYC);

  lzpd_cmd_type cmd; // Decoded command
  lzpd_state_type state; // Power state
  lzpd_state_type next_state; // Next power state
  logic cke_prev; // Enable level at previous edge
  logic [`LZPD_CNT_W-1:0] zq_cnt; // Calibration time left
  logic [`LZPD_CNT_W-1:0] xp_cnt; // Exit latency left
  logic zq_cmd; // Calibration command this edge
  logic tied; // Caught resistor strap
  logic [2:0] tied_sync; // Strap synchroniser stages, oldest on top

  // True in either light power-down state; used by the exit counter and the status bundle
  function automatic logic in_light_pd(input lzpd_state_type s);
    return (s == LZPD_ST_PPD) || (s == LZPD_ST_APD);
  endfunction

  // Command decoder
  lzpd_cmd_decode u_dec
  (
    .cs_n(CS_N),
    .ca_rise(CA_RISE),
    .ca_fall(CA_FALL),
    .cmd(cmd)
  );

  // Calibration command is a mode write to the calibration address
  // Refused outside the active state and while exit latency runs
  assign zq_cmd = (state == LZPD_ST_ACTIVE) && (xp_cnt == '0) && CKE && cke_prev && cmd.mrw
                  && (cmd.ma == `LZPD_MA_ZQ);

  // Enable sampled on every edge, power-down included
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      cke_prev <= 1'b1;
    else
      cke_prev <= CKE;
  end

  // Strap pin shifts through three stages; no reset, the chain fills itself
  always_ff @(posedge REF_CLK)
  begin
    tied_sync <= {tied_sync[1:0], ZQ_TIED_HIGH};
  end

  // Strap level taken once the last two stages agree, so a glitch is not caught
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      tied <= 1'b0;
    else if (tied_sync[1] == tied_sync[2])
      tied <= tied_sync[2];
  end

  // Next power state
  always_comb
  begin
    next_state = state;
    unique case (state)
      LZPD_ST_ACTIVE:
      begin
        // Entry on enable falling edge
        if (cke_prev && !CKE)
        begin
          // Deep pattern checked first, it overrides plain power-down
          if (cmd.dpd)
            next_state = LZPD_ST_DPD;
          else if (CS_N)
            next_state = BANKS_OPEN ? LZPD_ST_APD : LZPD_ST_PPD;
        end
      end
      LZPD_ST_PPD, LZPD_ST_APD:
      begin
        // Exit when enable registered high
        if (CKE)
          next_state = LZPD_ST_EXIT;
      end
      LZPD_ST_EXIT:
      begin
        // Commands stay refused until the latency runs out
        if (xp_cnt == `LZPD_CNT_W'(1))
          next_state = LZPD_ST_ACTIVE;
      end
      LZPD_ST_DPD:
      begin
        // Any enable high wakes the die; contents are not kept
        if (CKE)
          next_state = LZPD_ST_UNINIT;
      end
      LZPD_ST_UNINIT:
      begin
        // Core reports when the full start-up has been redone
        if (INIT_DONE)
          next_state = LZPD_ST_ACTIVE;
      end
      default: next_state = LZPD_ST_ACTIVE;
    endcase
  end

  // Power state register
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      state <= LZPD_ST_ACTIVE;
    else
      state <= next_state;
  end

  // Exit latency counter; commands ignored until it expires
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      xp_cnt <= '0;
    // Loaded on the edge that registers enable high in power-down
    else if (in_light_pd(state) && CKE)
      xp_cnt <= (XP_LD == '0) ? `LZPD_CNT_W'(1) : XP_LD;
    else if (xp_cnt != '0)
      xp_cnt <= xp_cnt - `LZPD_CNT_W'(1);
  end

  // Calibration timer and code selection
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      zq_cnt <= '0;
      ZQ_CODE_SEL <= 2'b00;
    end
    // A new init, long or short command while busy restarts the timer
    else if (zq_cmd && !tied)
    begin
      unique case (cmd.op)
        `LZPD_ZQ_INIT: zq_cnt <= ZQINIT_LD;
        `LZPD_ZQ_LONG: zq_cnt <= ZQCL_LD;
        `LZPD_ZQ_SHORT: zq_cnt <= ZQCS_LD;
        `LZPD_ZQ_RESET:
        begin
          // Reset has no calibration period
          zq_cnt <= '0;
          ZQ_CODE_SEL <= 2'b00;
        end
        // Unknown codes leave the timer as it is
        default: zq_cnt <= zq_cnt;
      endcase
    end
    else if (zq_cnt != '0)
    begin
      zq_cnt <= zq_cnt - `LZPD_CNT_W'(1);
      // Calibrated code takes over at the end
      if (zq_cnt == `LZPD_CNT_W'(1))
        ZQ_CODE_SEL <= 2'b01;
    end
  end

  // Current path only while calibrating
  assign ZQ_CURRENT_EN = (zq_cnt != '0);
  // Busy flag mirrors the same timer
  assign ZQ_BUSY = (zq_cnt != '0);

  // Buffer and supply gating by power state
  always_comb
  begin
    // Only clock and enable inputs live in power-down
    INPUT_BUF_EN = (state == LZPD_ST_ACTIVE) || (state == LZPD_ST_EXIT) || (state == LZPD_ST_UNINIT);
    // Outputs follow the inputs
    OUTPUT_BUF_EN = INPUT_BUF_EN;
    // Internal supply off in deep power-down
    CORE_POWER_EN = (state != LZPD_ST_DPD);
    // No refresh in either power-down
    REFRESH_EN = (state == LZPD_ST_ACTIVE) || (state == LZPD_ST_EXIT);
  end

  // Status bundle
  always_comb
  begin
    STATUS.in_pd = in_light_pd(state);
    STATUS.active_pd = (state == LZPD_ST_APD);
    STATUS.in_dpd = (state == LZPD_ST_DPD);
    STATUS.need_init = (state == LZPD_ST_UNINIT);
    // Commands accepted only once exit latency is over
    STATUS.cmd_ready = (state == LZPD_ST_ACTIVE) && (xp_cnt == '0);
  end
endmodule

//--- hdl/lzpd_params.svh
/*
  Constants for the calibration and power-down state keeper of the memory die.
  Assumes inclusion by the top design module only.
*/
`ifndef LZPD_PARAMS_SVH
`define LZPD_PARAMS_SVH
// Clock period in ns
`define LZPD_CLK_NS 100
// Calibration times in ns
`define LZPD_T_ZQINIT_NS 1000000
`define LZPD_T_ZQCL_NS 360000
`define LZPD_T_ZQCS_NS 90000
// Exit latency in ns
`define LZPD_T_XP_NS 7500
// Cycle counts: least times round up
`define LZPD_ZQINIT_CYC ((`LZPD_T_ZQINIT_NS + `LZPD_CLK_NS - 1) / `LZPD_CLK_NS)
`define LZPD_ZQCL_CYC ((`LZPD_T_ZQCL_NS + `LZPD_CLK_NS - 1) / `LZPD_CLK_NS)
`define LZPD_ZQCS_CYC ((`LZPD_T_ZQCS_NS + `LZPD_CLK_NS - 1) / `LZPD_CLK_NS)
`define LZPD_XP_CYC ((`LZPD_T_XP_NS + `LZPD_CLK_NS - 1) / `LZPD_CLK_NS)
// Calibration codes in the written data byte
`define LZPD_ZQ_INIT 8'hff
`define LZPD_ZQ_LONG 8'hab
`define LZPD_ZQ_SHORT 8'h56
`define LZPD_ZQ_RESET 8'hc3
// Mode register address of calibration command
`define LZPD_MA_ZQ 8'h0a
// Counter width
`define LZPD_CNT_W 14
`endif

//--- hdl/lzpd_pkg.sv
/*
  Types for the calibration and power-down state keeper.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package lzpd_pkg;
  // Power state of the die
  typedef enum logic [2:0]
  {
    LZPD_ST_ACTIVE = 3'b000,
    LZPD_ST_PPD = 3'b001,
    LZPD_ST_APD = 3'b010,
    LZPD_ST_EXIT = 3'b011,
    LZPD_ST_DPD = 3'b100,
    LZPD_ST_UNINIT = 3'b101
  } lzpd_state_type;
  // Decoded command of one edge
  typedef struct packed
  {
    logic nop;
    logic mrw;
    logic dpd;
    logic [7:0] ma;
    logic [7:0] op;
  } lzpd_cmd_type;
  // Status bundle
  typedef struct packed
  {
    logic in_pd;
    logic active_pd;
    logic in_dpd;
    logic need_init;
    logic cmd_ready;
  } lzpd_status_type;
endpackage

//--- hdl/lzpd_cmd_decode.sv
/*
  Decodes the command bus of one rising edge into a command struct.
  Assumes the rising and falling halves are already captured and aligned.
*/
module lzpd_cmd_decode
  import lzpd_pkg::*;
(
  input wire logic cs_n,
  input wire logic [9:0] ca_rise,
  input wire logic [9:0] ca_fall,
  output lzpd_cmd_type cmd
);
  // Pure decode of select and CA bits
  always_comb
  begin
    // No-operation: select high, or CA0..2 all high
    cmd.nop = cs_n | (ca_rise[0] & ca_rise[1] & ca_rise[2]);
    // Mode write: CA0..3 all low
    cmd.mrw = ~cs_n & (ca_rise[3:0] == 4'h0);
    // Deep power-down pattern CA 1-1-0
    cmd.dpd = ~cs_n & ca_rise[0] & ca_rise[1] & ~ca_rise[2];
    cmd.ma = {ca_fall[1:0], ca_rise[9:4]};
    cmd.op = ca_fall[9:2];
  end
endmodule

//--- tb/lzpd_ctrl_props.sv
/*
  Port checker for the calibration and power-down keeper.
  Assumes it is bound to lzpd_ctrl and sees only that module's ports.
*/
module lzpd_ctrl_props
  import lzpd_pkg::*;
#(
  parameter int ZQCS_CYC = 3,
  parameter int XP_CYC = 2
)
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CKE,
  input wire logic CS_N,
  input wire logic [9:0] CA_RISE,
  input wire logic [9:0] CA_FALL,
  input wire logic BANKS_OPEN,
  input wire logic ZQ_TIED_HIGH,
  input wire logic INIT_DONE,
  input wire logic ZQ_CURRENT_EN,
  input wire logic ZQ_BUSY,
  input wire logic [1:0] ZQ_CODE_SEL,
  input wire logic INPUT_BUF_EN,
  input wire logic OUTPUT_BUF_EN,
  input wire logic CORE_POWER_EN,
  input wire logic REFRESH_EN,
  input wire lzpd_status_type STATUS
);
  // Calibration register write seen on the bus
  wire zq_ma = !CS_N && CA_RISE[3:0] == 4'h0 && {CA_FALL[1:0], CA_RISE[9:4]} == 8'h0a;
  // Die idle and ready for commands
  wire idle = STATUS.cmd_ready && !STATUS.need_init && !STATUS.in_pd && !STATUS.in_dpd && !ZQ_BUSY;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // Short calibration with a fitted resistor
  sequence s_zq_short;
    idle && zq_ma && CKE && $past(CKE) && CA_FALL[9:2] == 8'h56
      && !$past(ZQ_TIED_HIGH, 3) && !$past(ZQ_TIED_HIGH, 4);
  endsequence
  // Enable falls from an idle die
  sequence s_drop;
    idle && $past(CKE) && !CKE;
  endsequence
  a_pd_entry: assert property (s_drop ##0 CS_N |=> STATUS.in_pd && STATUS.active_pd == $past(BANKS_OPEN))
    else $error("power-down entry wrong");
  a_pd_quiet: assert property (STATUS.in_pd |-> !INPUT_BUF_EN && !OUTPUT_BUF_EN && !REFRESH_EN)
    else $error("buffers or refresh on in power-down");
  a_pd_hold: assert property (STATUS.in_pd && !CKE |=> STATUS.in_pd)
    else $error("power-down left with enable low");
  a_exit_wait: assert property (STATUS.in_pd && CKE |=> !STATUS.cmd_ready [*2] ##1 STATUS.cmd_ready)
    else $error("exit latency wrong");
  a_dpd_entry: assert property (s_drop ##0 !CS_N && CA_RISE[2:0] == 3'b011 |=> STATUS.in_dpd && !CORE_POWER_EN)
    else $error("deep entry wrong");
  a_dpd_exit: assert property (STATUS.in_dpd && CKE |=> !STATUS.in_dpd && STATUS.need_init)
    else $error("deep exit wrong");
  a_init_wait: assert property (STATUS.need_init && !INIT_DONE |=> STATUS.need_init)
    else $error("init need dropped early");
  a_zq_short: assert property (s_zq_short |=> ZQ_BUSY [*3] ##1 (!ZQ_BUSY && !ZQ_CURRENT_EN && ZQ_CODE_SEL == 2'b01))
    else $error("short calibration wrong");
  a_zq_current: assert property (ZQ_CURRENT_EN == ZQ_BUSY)
    else $error("calibration current wrong");
  a_zq_tied: assert property (idle && zq_ma && CKE && $past(CKE) && $past(ZQ_TIED_HIGH, 3) && $past(ZQ_TIED_HIGH, 4)
    |=> !ZQ_BUSY && $stable(ZQ_CODE_SEL))
    else $error("calibration not ignored");
  a_nop_idle: assert property (idle && CKE && $past(CKE) && (CS_N || CA_RISE[2:0] == 3'b111)
    |=> !ZQ_BUSY && STATUS.cmd_ready && !STATUS.in_pd)
    else $error("no-operation had effect");
endmodule
bind lzpd_ctrl lzpd_ctrl_props #(.ZQCS_CYC(ZQCS_CYC), .XP_CYC(XP_CYC)) u_lzpd_ctrl_props (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .CKE(CKE), .CS_N(CS_N), .CA_RISE(CA_RISE), .CA_FALL(CA_FALL),
  .BANKS_OPEN(BANKS_OPEN), .ZQ_TIED_HIGH(ZQ_TIED_HIGH), .INIT_DONE(INIT_DONE),
  .ZQ_CURRENT_EN(ZQ_CURRENT_EN), .ZQ_BUSY(ZQ_BUSY), .ZQ_CODE_SEL(ZQ_CODE_SEL),
  .INPUT_BUF_EN(INPUT_BUF_EN), .OUTPUT_BUF_EN(OUTPUT_BUF_EN), .CORE_POWER_EN(CORE_POWER_EN),
  .REFRESH_EN(REFRESH_EN), .STATUS(STATUS));

//--- tb/lzpd_host_model.sv
/*
  Memory controller model driving enable, select and command bus.
  Assumes the caller sequences commands from idle.
*/
module lzpd_host_model (
  input wire logic ref_clk,
  output logic cke,
  output logic cs_n,
  output logic [9:0] ca_rise,
  output logic [9:0] ca_fall
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial
  begin
    cke = 1'b1;
    cs_n = 1'b1;
    ca_rise = 10'h000;
    ca_fall = 10'h000;
  end
  // One command, changed just after a rising edge
  task automatic send(input logic k, input logic s, input logic [9:0] r, input logic [9:0] f);
    @(posedge ref_clk);
    cke <= k;
    cs_n <= s;
    ca_rise <= r;
    ca_fall <= f;
  endtask
  // Select high; unused bus shows the inverse of its last value
  task automatic nop(input logic k);
    send(k, 1'b1, ~ca_rise, ~ca_fall);
  endtask
  // Calibration write, issued only from idle with banks closed; one die, no data traffic
  task automatic zq(input logic [7:0] op);
    send(1'b1, 1'b0, 10'h0a0, {op, 2'b00});
    nop(1'b1);
  endtask
  // Power-down or deep entry, then a no-operation with enable low
  // Only called with no read, write or mode access pending, so every hold has run out
  task automatic enter(input logic deep);
    send(1'b0, ~deep, 10'h003, 10'h000);
    nop(1'b0);
  endtask
endmodule

//--- tb/test_lzpd_ctrl.sv
/*
  Self-checking bench for the calibration and power-down keeper.
  Assumes the host model drives the command side.
*/
module test_lzpd_ctrl
  import lzpd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, banks_open, zq_tied, init_done;
  wire cke, cs_n, zq_cur, zq_busy, ibuf, obuf, core_pwr, refr;
  wire [9:0] ca_rise, ca_fall;
  wire [1:0] code;
  wire lzpd_status_type st;
  int n_mismatch = 0, total_checks = 0;
  // Free-running clock, 100 ns period
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  lzpd_host_model u_lzpd_host_model (.ref_clk(clk), .cke(cke), .cs_n(cs_n), .ca_rise(ca_rise), .ca_fall(ca_fall));
  lzpd_ctrl #(.ZQINIT_CYC(5), .ZQCL_CYC(4), .ZQCS_CYC(3), .XP_CYC(2)) u_lzpd_ctrl (
    .REF_CLK(clk), .RST_N(rst_n), .CKE(cke), .CS_N(cs_n), .CA_RISE(ca_rise), .CA_FALL(ca_fall),
    .BANKS_OPEN(banks_open), .ZQ_TIED_HIGH(zq_tied), .INIT_DONE(init_done), .ZQ_CURRENT_EN(zq_cur),
    .ZQ_BUSY(zq_busy), .ZQ_CODE_SEL(code), .INPUT_BUF_EN(ibuf), .OUTPUT_BUF_EN(obuf),
    .CORE_POWER_EN(core_pwr), .REFRESH_EN(refr), .STATUS(st));
  // Compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Count cycles with calibration busy, from the edge that takes the command
  task automatic count_busy(output int n);
    n = 0;
    repeat (12)
    begin
      #1;
      if (zq_busy === 1'b1) n++;
      @(posedge clk);
    end
  endtask
  // Each calibration code, timed, with its resulting impedance code
  task automatic t_zq;
    logic [7:0] ops [5] = '{8'hff, 8'hab, 8'h56, 8'hc3, 8'h5a}; // Last code is unknown and refused
    int lens [5] = '{5, 4, 3, 0, 0};
    int n;
    for (int i = 0; i < 5; i++)
    begin
      u_lzpd_host_model.zq(ops[i]);
      count_busy(n);
      check("zq busy", 8'(n), 8'(lens[i]));
      check("zq code", 8'(code), (i < 3) ? 8'h01 : 8'h00);
      check("zq current", 8'(zq_cur), 8'h00);
    end
  endtask
  // Resistor absent: calibration ignored
  task automatic t_tied;
    int n;
    @(posedge clk);
    zq_tied <= 1'b1;
    repeat (4) @(posedge clk); // Strap passes the pin synchroniser first
    u_lzpd_host_model.zq(8'h56);
    count_busy(n);
    check("tied busy", 8'(n), 8'h00);
    check("tied code", 8'(code), 8'h00);
    zq_tied <= 1'b0;
  endtask
  // Power-down entry, residency, exit latency
  task automatic t_pd(input logic open);
    int n;
    @(posedge clk);
    banks_open <= open;
    u_lzpd_host_model.enter(1'b0);
    #1;
    check("pd state", 8'({st.in_pd, st.active_pd, ibuf, obuf, refr}), {3'h0, 1'b1, open, 3'h0});
    repeat (3) u_lzpd_host_model.nop(1'b0);
    #1;
    check("pd held", 8'(st.in_pd), 8'h01);
    u_lzpd_host_model.nop(1'b1);
    n = 0;
    repeat (8)
    begin
      @(posedge clk);
      #1;
      if (st.cmd_ready === 1'b0) n++;
    end
    check("exit latency", 8'(n), 8'h02);
    check("buffers back", 8'({ibuf, obuf, refr}), 8'h07);
  endtask
  // Deep power-down entry, exit, reinitialisation
  task automatic t_dpd;
    u_lzpd_host_model.enter(1'b1);
    #1;
    check("dpd state", 8'({st.in_dpd, core_pwr, obuf}), 8'h04);
    u_lzpd_host_model.nop(1'b1);
    @(posedge clk);
    #1;
    check("dpd exit", 8'({st.in_dpd, st.need_init}), 8'h01);
    @(posedge clk);
    init_done <= 1'b1;
    @(posedge clk);
    init_done <= 1'b0;
    #1;
    check("init done", 8'(st.need_init), 8'h00);
  endtask
  // Reset for 3 cycles, then the scenarios
  initial
  begin
    rst_n = 1'b0;
    banks_open = 1'b0;
    zq_tied = 1'b0;
    init_done = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_zq;
    t_tied;
    t_pd(1'b0);
    t_pd(1'b1);
    t_dpd;
    give_verdict;
  end
  // Hang guard, about twenty times the expected run
  initial
  begin
    #300000;
    n_mismatch++;
    give_verdict;
  end
endmodule
